// [hdl/hpc_fault_alert.sv]
// fault latch and alert line control for the hot-plug register bank
// assumes: events are one-cycle pulses, sys_clk domain only
`include "hpc_consts.svh"
`default_nettype none

module hpc_fault_alert #(
    parameter int FLT_W = 6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [FLT_W-1:0] flt_event,
    input wire logic flt_wr,
    input wire logic [FLT_W-1:0] flt_wr_data,
    input wire logic [FLT_W-1:0] alert_en,
    input wire logic alert_release,
    output logic [FLT_W-1:0] flt_q,
    output logic alert_low
);
    // the latch mirrors the six alert enables
    if (FLT_W != 6) begin : g_chk
        $error("hpc_fault_alert: FLT_W must be 6");
    end

    hpc_pkg::hpc_alert_state_type state_q; // alert line state
    hpc_pkg::hpc_alert_state_type state_d;
    logic [FLT_W-1:0] flt_d;   // next latch value
    logic [FLT_W-1:0] new_hit; // latch bits newly set and enabled
    wire logic [FLT_W-1:0] flt_base = flt_wr ? flt_wr_data : flt_q;

    // event set wins over a host clear in the same cycle
    assign flt_d = flt_base | flt_event;
    // only a freshly set bit pulls again, so a standing fault stays quiet
    assign new_hit = flt_event & ~flt_q & alert_en;

    // alert state: new enabled fault pulls, release frees the line
    always_comb begin
        state_d = state_q;
        case (state_q)
            hpc_pkg::HPC_ALR_IDLE: begin
                if (|new_hit) begin
                    state_d = hpc_pkg::HPC_ALR_PULL;
                end
            end
            hpc_pkg::HPC_ALR_PULL: begin
                if (alert_release && !(|new_hit)) begin
                    state_d = hpc_pkg::HPC_ALR_IDLE;
                end
            end
            default: begin
                state_d = hpc_pkg::HPC_ALR_IDLE;
            end
        endcase
    end

    // latch and state registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_q <= `HPC_FLT_RST;
            state_q <= hpc_pkg::HPC_ALR_IDLE;
        end else begin
            flt_q <= flt_d;
            state_q <= state_d;
        end
    end

    assign alert_low = (state_q == hpc_pkg::HPC_ALR_PULL);

    AST_ALERT_PULL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (|(flt_event & ~flt_q & alert_en)) |=> alert_low)
        else $error("enabled new fault did not pull alert");

    AST_ALERT_FREE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (alert_low && alert_release && !(|(flt_event & ~flt_q & alert_en)))
        |=> !alert_low ##1 (!alert_low || $past(|flt_event)))
        else $error("alert not released after response");

    AST_FLT_STICKY: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (|flt_event) |=> ((flt_q & $past(flt_event)) == $past(flt_event)))
        else $error("fault event not latched");
endmodule : hpc_fault_alert

`default_nettype wire

// [hdl/hpc_regs.sv]
// control, alert-enable and status registers of a hot-plug controller
// assumes: the serial engine hands over decoded strobes in hpc_host_req_type
// and all pins are synchronous to sys_clk
`include "hpc_consts.svh"
`default_nettype none

module hpc_regs #(
    parameter bit EXT_FILTER = 1'b0, // extended circuit breaker variant
    parameter int REG_W = 8          // register width
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire hpc_pkg::hpc_host_req_type host,
    input wire hpc_pkg::hpc_pins_type pins,
    input wire logic [6:0] dev_addr,
    input wire logic gpio_i,
    output logic gpio_o,
    output logic gpio_oe_n,
    output logic [7:0] rd_data,
    output logic mass_accept,
    output logic ara_claim,
    output logic [7:0] ara_data,
    output logic alert_o,
    output logic alert_oe_n,
    output logic fet_on_cmd,
    output logic adc_disable,
    output logic oc_retry,
    output logic uv_retry,
    output logic ov_retry
);
    // every field position below assumes byte-wide registers
    if (REG_W != 8) begin : g_chk
        $error("hpc_regs: REG_W must be 8");
    end

    // reset value of the control register depends on the filter variant
    localparam logic [7:0] CTRL_RST =
        EXT_FILTER ? `HPC_CTRL_RST_EXT : `HPC_CTRL_RST_FAST;

    logic [7:0] ctrl_q;  // power_path_control
    logic [7:0] ctrl_d;
    logic [7:0] alrt_q;  // alert_enable_and_gpio_out
    logic [7:0] alrt_d;
    logic [2:0] ptr_q;   // register pointer
    logic [2:0] ptr_d;
    logic [7:0] rd_data_q; // read data held for the serial engine
    logic [7:0] rd_data_d;
    logic gpio_o_q;      // registered pin data
    logic gpio_o_d;
    logic gpio_oe_n_q;   // registered pin enable, low = driving
    logic gpio_oe_n_d;
    logic [7:0] ara_q;   // address byte returned on alert response
    logic [7:0] stat_q;  // previous status, for fault edges
    logic [5:0] flt_q;   // fault latch from the helper
    logic alert_low;     // helper wants the alert line low

    // write qualification: own address always, mass address when enabled
    wire logic mass_en = ctrl_q[`HPC_CTRL_MASS];
    wire logic wr_ok = host.wr_stb &&
        (host.own_sel || (host.mass_sel && mass_en));
    wire logic wr_ctrl = wr_ok && (ptr_q == `HPC_OFS_CTRL);
    wire logic wr_alrt = wr_ok && (ptr_q == `HPC_OFS_ALRT);
    wire logic wr_flt = wr_ok && (ptr_q == `HPC_OFS_FLT);

    // pin mode decode
    wire hpc_pkg::hpc_pin_mode_type pin_mode =
        hpc_pkg::hpc_pin_mode_type'(
            ctrl_q[`HPC_CTRL_MODE_HI:`HPC_CTRL_MODE_LO]);

    // live conditions, straight from pins; only the short flag is gated by the stored fet-on bit
    wire logic st_pbad = !pins.output_monitor_pin;
    wire logic st_short = pins.sense_over_1mv &&
        !ctrl_q[`HPC_CTRL_FETON];
    wire logic [7:0] stat_w = {
        pins.fet_is_on,
        gpio_i,
        st_short,
        !pins.en_pin_n,
        st_pbad,
        pins.oc_cooldown,
        !pins.low_supply_comparator_pin,
        pins.high_supply_comparator_pin
    };

    // fault events: rising edges, plus any change of the enable pin
    wire logic [5:0] flt_event = {
        stat_w[`HPC_ST_SHORT] & ~stat_q[`HPC_ST_SHORT],
        stat_w[`HPC_ST_EN] ^ stat_q[`HPC_ST_EN],
        stat_w[`HPC_ST_PBAD] & ~stat_q[`HPC_ST_PBAD],
        stat_w[`HPC_ST_OC] & ~stat_q[`HPC_ST_OC],
        stat_w[`HPC_ST_UV] & ~stat_q[`HPC_ST_UV],
        stat_w[`HPC_ST_OV] & ~stat_q[`HPC_ST_OV]
    };

    // alert freed by the response address or by being addressed
    wire logic claim = host.ara_rd && alert_low;
    wire logic release_w = claim || host.addr_stb;

    // pointer keeps only the low three command bits
    assign ptr_d = host.cmd_stb ? host.cmd_byte[2:0] : ptr_q;

    // control register: debounce end overrides the fet-on bit of a same-cycle host write
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = host.wr_data;
        end
        if (pins.debounce_done) begin
            ctrl_d[`HPC_CTRL_FETON] = pins.on_pin;
        end
    end

    // alert register: bit 7 reserved, never stored
    assign alrt_d = wr_alrt ? (host.wr_data & `HPC_ALRT_WMASK)
                            : alrt_q;

    // read mux, status is live; unmapped pointers read zero
    always_comb begin
        case (ptr_q)
            `HPC_OFS_CTRL: rd_data_d = ctrl_q;
            `HPC_OFS_ALRT: rd_data_d = alrt_q;
            `HPC_OFS_STAT: rd_data_d = stat_w;
            `HPC_OFS_FLT: rd_data_d = {2'h0, flt_q};
            default: rd_data_d = `HPC_ZERO8;
        endcase
    end

    // gpio pin source by mode
    always_comb begin
        gpio_o_d = 1'b0;
        gpio_oe_n_d = 1'b0;
        case (pin_mode)
            hpc_pkg::HPC_PIN_PGOOD_N: gpio_o_d = !st_pbad;
            hpc_pkg::HPC_PIN_PGOOD: gpio_o_d = st_pbad;
            hpc_pkg::HPC_PIN_OUT: gpio_o_d = alrt_q[`HPC_ALRT_GPO];
            hpc_pkg::HPC_PIN_IN: gpio_oe_n_d = 1'b1;
            default: gpio_oe_n_d = 1'b1;
        endcase
    end

    // host-visible registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            alrt_q <= `HPC_ALRT_RST;
            ptr_q <= `HPC_OFS_CTRL;
        end else begin
            ctrl_q <= ctrl_d;
            alrt_q <= alrt_d;
            ptr_q <= ptr_d;
        end
    end

    // output and history registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= `HPC_RD_RST;
            gpio_o_q <= 1'b1;
            gpio_oe_n_q <= 1'b0;
            stat_q <= `HPC_ZERO8;
            ara_q <= `HPC_ZERO8;
        end else begin
            rd_data_q <= rd_data_d;
            gpio_o_q <= gpio_o_d;
            gpio_oe_n_q <= gpio_oe_n_d;
            stat_q <= stat_w;
            ara_q <= {dev_addr, 1'b0};
        end
    end

    // fault latch and alert line
    hpc_fault_alert #(
        .FLT_W(6)
    ) u_fault_alert (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flt_event(flt_event),
        .flt_wr(wr_flt),
        .flt_wr_data(host.wr_data[5:0]),
        .alert_en(alrt_q[`HPC_ALRT_EN_HI:0]),
        .alert_release(release_w),
        .flt_q(flt_q),
        .alert_low(alert_low)
    );

    // outputs; alert is open drain: enable low pulls the line low
    assign rd_data = rd_data_q;
    assign gpio_o = gpio_o_q;
    assign gpio_oe_n = gpio_oe_n_q;
    assign mass_accept = mass_en;
    assign ara_claim = claim;
    assign ara_data = ara_q;
    assign alert_o = 1'b0;
    assign alert_oe_n = !alert_low;
    assign fet_on_cmd = ctrl_q[`HPC_CTRL_FETON];
    assign adc_disable = ctrl_q[`HPC_CTRL_TEST];
    assign oc_retry = ctrl_q[`HPC_CTRL_OCRT];
    assign uv_retry = ctrl_q[`HPC_CTRL_UVRT];
    assign ov_retry = ctrl_q[`HPC_CTRL_OVRT];

    AST_PIN_PGOOD_N: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[7:6] == 2'h0) |=>
            (gpio_o == $past(pins.output_monitor_pin)) && !gpio_oe_n)
        else $error("gpio pin not inverted power bad");

    AST_PIN_INPUT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[7:6] == 2'h3) |=> gpio_oe_n)
        else $error("gpio pin driven in input mode");

    AST_GPIO_STATUS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ptr_q == 3'h2) |=> rd_data[6] == $past(gpio_i))
        else $error("status does not show gpio level");

    AST_MASS_IGNORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (host.wr_stb && host.mass_sel && !host.own_sel &&
         !ctrl_q[4] && ptr_q == 3'h1) |=> $stable(alrt_q))
        else $error("mass write taken while disabled");

    AST_DEBOUNCE_LOAD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pins.debounce_done |=> fet_on_cmd == $past(pins.on_pin))
        else $error("fet-on bit not loaded from on pin");

    AST_SHORT_STATUS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ptr_q == 3'h2) |=>
            rd_data[5] == $past(pins.sense_over_1mv && !fet_on_cmd))
        else $error("fet short status wrong");

    AST_STATUS_RO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_ok && ptr_q == 3'h2 && !pins.debounce_done) |=>
            $stable(ctrl_q) && $stable(alrt_q))
        else $error("status write changed a register");

    AST_PTR_LOW3: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host.cmd_stb |=> ptr_q == $past(host.cmd_byte[2:0]))
        else $error("pointer not low three command bits");

    AST_RSVD_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ptr_q == 3'h1 || ptr_q[2]) ##1 1'b1 |->
            !rd_data[7])
        else $error("reserved bit read as one");

    AST_ALERT_PIN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (claim && !(|(flt_event & ~flt_q & alrt_q[5:0]))) |=>
            !alert_low ##1 (alert_oe_n || $past(|flt_event)))
        else $error("alert line not released after claim");
endmodule : hpc_regs

`default_nettype wire

// [pkg/hpc_consts.svh]
// offsets, field positions and reset values of the hot-plug register bank
// assumes: included by bare name from pkg/ and hdl/ files
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// register pointer values (low three bits of the command byte)
`define HPC_OFS_CTRL 3'h0
`define HPC_OFS_ALRT 3'h1
`define HPC_OFS_STAT 3'h2
`define HPC_OFS_FLT 3'h3

// power_path_control fields
`define HPC_CTRL_MODE_HI 7
`define HPC_CTRL_MODE_LO 6
`define HPC_CTRL_TEST 5
`define HPC_CTRL_MASS 4
`define HPC_CTRL_FETON 3
`define HPC_CTRL_OCRT 2
`define HPC_CTRL_UVRT 1
`define HPC_CTRL_OVRT 0

// alert_enable_and_gpio_out fields
`define HPC_ALRT_GPO 6
`define HPC_ALRT_EN_HI 5

// live_condition_flags fields, also fault latch positions below bit 6
`define HPC_ST_FET 7
`define HPC_ST_GPIO 6
`define HPC_ST_SHORT 5
`define HPC_ST_EN 4
`define HPC_ST_PBAD 3
`define HPC_ST_OC 2
`define HPC_ST_UV 1
`define HPC_ST_OV 0

// reset values
`define HPC_CTRL_RST_FAST 8'h13
`define HPC_CTRL_RST_EXT 8'h17
`define HPC_ALRT_RST 8'h00
`define HPC_ALRT_WMASK 8'h7F
`define HPC_FLT_RST 6'h00
`define HPC_RD_RST 8'h00
`define HPC_ZERO8 8'h00

`endif

// [pkg/hpc_pkg.sv]
// types shared by the hot-plug register bank and its fault/alert helper
// assumes: compiled before any hdl/ file
`default_nettype none

package hpc_pkg;
    // pin_mode_field decode
    typedef enum logic [1:0] {
        HPC_PIN_PGOOD_N = 2'h0, // pin shows inverted power bad
        HPC_PIN_PGOOD = 2'h1,   // pin shows power bad
        HPC_PIN_OUT = 2'h2,     // pin shows the gpio output bit
        HPC_PIN_IN = 2'h3       // pin released, used as input
    } hpc_pin_mode_type;

    // alert line state, gray along idle -> pulled
    typedef enum logic {
        HPC_ALR_IDLE = 1'b0,
        HPC_ALR_PULL = 1'b1
    } hpc_alert_state_type;

    // register access from the serial protocol engine
    typedef struct packed {
        logic own_sel;   // transaction aimed at own address (level)
        logic mass_sel;  // transaction aimed at mass-write address (level)
        logic addr_stb;  // own address just matched (pulse)
        logic ara_rd;    // alert response address read seen (pulse)
        logic cmd_stb;   // command byte received (pulse)
        logic [7:0] cmd_byte;
        logic wr_stb;    // data byte received (pulse)
        logic [7:0] wr_data;
    } hpc_host_req_type;

    // analog comparators and control-path pins
    typedef struct packed {
        logic on_pin;                     // turn-on request
        logic en_pin_n;                   // card enable, low = enabled
        logic output_monitor_pin;         // low = power bad
        logic low_supply_comparator_pin;  // low = undervoltage
        logic high_supply_comparator_pin; // high = overvoltage
        logic sense_over_1mv;             // sense voltage above 1mV
        logic fet_is_on;                  // actual pass-FET state
        logic oc_cooldown;                // overcurrent cool-down active
        logic debounce_done;              // end of turn-on debounce (pulse)
    } hpc_pins_type;
endpackage : hpc_pkg

`default_nettype wire

// [testbench/hpc_host_model.sv]
// host-side model: drives the decoded request struct of the register bank
// assumes: one sys_clk domain; every strobe is held for one whole cycle
`default_nettype none

module hpc_host_model (
    input wire logic sys_clk,
    input wire logic ara_claim,
    output var hpc_pkg::hpc_host_req_type host
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: strobes low, data lines carry junk, never a stale byte
    initial begin
        host = '0;
        host.cmd_byte = 8'hA5;
        host.wr_data = 8'h5A;
    end

    // command byte; only its low three bits should steer the pointer
    task automatic set_ptr(input logic [7:0] cmd);
        @(posedge sys_clk);
        #1;
        host.cmd_stb = 1'b1;
        host.cmd_byte = cmd;
        @(posedge sys_clk);
        #1;
        host.cmd_stb = 1'b0;
        host.cmd_byte = ~cmd; // released: inverse so a stale use shows
    endtask : set_ptr

    // one data byte to the own address or to the shared mass address
    task automatic write_byte(input logic own, input logic mass,
                              input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        host.own_sel = own;
        host.mass_sel = mass;
        host.wr_stb = 1'b1;
        host.wr_data = data;
        @(posedge sys_clk);
        #1;
        host.own_sel = 1'b0;
        host.mass_sel = 1'b0;
        host.wr_stb = 1'b0;
        host.wr_data = ~data;
    endtask : write_byte

    // alert response read; the claim is taken while the request stands
    task automatic ara_query(output logic claim);
        @(posedge sys_clk);
        #1;
        host.ara_rd = 1'b1;
        @(posedge sys_clk);
        claim = ara_claim; // taken at the edge that takes the request
        #1;
        host.ara_rd = 1'b0;
    endtask : ara_query

    // own address matched on the bus
    task automatic addr_hit();
        @(posedge sys_clk);
        #1;
        host.addr_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        host.addr_stb = 1'b0;
    endtask : addr_hit
endmodule : hpc_host_model

`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the hot-plug control/alert/status registers
// assumes: fast filter variant, host model drives the request struct
`default_nettype none
`define CHECK_EQ(g, e) chk_val(8'(g), 8'(e))

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] OWN_ADDR = 7'h4B; // any legal address
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    hpc_pkg::hpc_host_req_type host;
    hpc_pkg::hpc_pins_type pins = 9'h0E0; // idle: no condition active
    logic ext_level = 1'b0; // far end level once the pin is released
    logic gpio_o, gpio_oe_n, mass_accept, ara_claim, alert_o, alert_oe_n;
    logic fet_on_cmd, adc_disable, oc_retry, uv_retry, ov_retry;
    logic [7:0] rd_data, ara_data, v;
    logic claim;
    int error_cnt = 0;
    int samples_checked = 0;
    // resolved pin: design drives only while its enable is low
    wire logic gpio_i = gpio_oe_n ? ext_level : gpio_o;
    wire logic [5:0] knobs = {oc_retry, uv_retry, ov_retry, adc_disable,
                              mass_accept, fet_on_cmd};

    // clock: 25 MHz
    always #20 sys_clk = ~sys_clk;

    hpc_regs #(.EXT_FILTER(1'b0), .REG_W(8)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .host(host), .pins(pins),
        .dev_addr(OWN_ADDR), .gpio_i(gpio_i), .gpio_o(gpio_o),
        .gpio_oe_n(gpio_oe_n), .rd_data(rd_data),
        .mass_accept(mass_accept), .ara_claim(ara_claim),
        .ara_data(ara_data), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
        .fet_on_cmd(fet_on_cmd), .adc_disable(adc_disable),
        .oc_retry(oc_retry), .uv_retry(uv_retry), .ov_retry(ov_retry));

    hpc_host_model host_u (.sys_clk(sys_clk), .ara_claim(ara_claim),
                           .host(host));

    // single comparison point, four-state exact
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_val

    task automatic rd(input logic [7:0] cmd, output logic [7:0] val);
        host_u.set_ptr(cmd);
        @(posedge sys_clk);
        #1;
        val = rd_data; // registered one edge after the pointer moves
    endtask : rd

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        host_u.set_ptr(cmd);
        host_u.write_byte(1'b1, 1'b0, data);
    endtask : wr

    task automatic edges(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : edges

    // reset values, pointer aliasing and an unmapped pointer
    task automatic t_reset_ptr();
        `CHECK_EQ(knobs, 6'h1A);
        rd(8'h00, v);
        `CHECK_EQ(v, 8'h13);
        rd(8'h01, v);
        `CHECK_EQ(v, 8'h00);
        rd(8'h02, v);
        `CHECK_EQ(v, 8'h40);
        rd(8'hF8, v);
        `CHECK_EQ(v, 8'h13);
        rd(8'h05, v);
        `CHECK_EQ(v, 8'h00);
        $display("test reset_ptr done");
    endtask : t_reset_ptr

    // control bits reach their outputs; mass address gated by bit 4
    task automatic t_ctrl_mass();
        wr(8'h00, 8'h2C);
        `CHECK_EQ(knobs, 6'h25);
        rd(8'h00, v);
        `CHECK_EQ(v, 8'h2C);
        host_u.set_ptr(8'h01);
        host_u.write_byte(1'b0, 1'b1, 8'h3F); // must be dropped
        rd(8'h01, v);
        `CHECK_EQ(v, 8'h00);
        wr(8'h00, 8'h13);
        host_u.set_ptr(8'h01);
        host_u.write_byte(1'b0, 1'b1, 8'h15);
        rd(8'h01, v);
        `CHECK_EQ(v, 8'h15);
        wr(8'h01, 8'hFF);
        rd(8'h01, v);
        `CHECK_EQ(v, 8'h7F);
        $display("test ctrl_mass done");
    endtask : t_ctrl_mass

    // live status for a table of pin patterns, writes to it ignored
    task automatic t_status();
        logic [6:0] pat [5] = '{7'h00, 7'h7F, 7'h2A, 7'h55, 7'h14};
        logic [6:0] p;
        logic [7:0] e; // expected status for the current pattern
        wr(8'h01, 8'h00);
        wr(8'h02, 8'hFF); // read-only: no effect expected
        foreach (pat[i]) begin
            p = pat[i];
            {pins.fet_is_on, pins.sense_over_1mv, pins.en_pin_n,
             pins.output_monitor_pin, pins.oc_cooldown,
             pins.low_supply_comparator_pin,
             pins.high_supply_comparator_pin} = p;
            rd(8'h02, v);
            e = {p[6], p[3], p[5], ~p[4], ~p[3], p[2], ~p[1], p[0]};
            `CHECK_EQ(v, e);
        end
        pins = 9'h0E0;
        $display("test status done");
    endtask : t_status

    // each pin mode with power bad present, released pin read back
    task automatic t_gpio();
        logic [3:0] exp_pin = 4'h6; // mode 3..0: ext, B6, pbad, ~pbad
        wr(8'h01, 8'h40);
        pins.output_monitor_pin = 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, {m[1:0], 6'h13});
            edges(2);
            `CHECK_EQ(gpio_oe_n, m == 3);
            `CHECK_EQ(gpio_i, exp_pin[m]);
            rd(8'h02, v);
            `CHECK_EQ(v[6], exp_pin[m]);
        end
        ext_level = 1'b1; // released pin now pulled high from outside
        rd(8'h02, v);
        `CHECK_EQ(v[6], 1'b1);
        ext_level = 1'b0;
        wr(8'h00, 8'h13);
        pins.output_monitor_pin = 1'b1;
        $display("test gpio done");
    endtask : t_gpio

    task automatic pulse_deb();
        @(posedge sys_clk);
        #1;
        pins.debounce_done = 1'b1;
        @(posedge sys_clk);
        #1;
        pins.debounce_done = 1'b0;
    endtask : pulse_deb

    // debounce end loads on pin, and beats a host write in that cycle
    task automatic t_debounce();
        pins.on_pin = 1'b1;
        pulse_deb();
        `CHECK_EQ(fet_on_cmd, 1'b1);
        pins.sense_over_1mv = 1'b1; // commanded on: no short
        rd(8'h02, v);
        `CHECK_EQ(v, 8'h40);
        pins.sense_over_1mv = 1'b0;
        pins.on_pin = 1'b0;
        host_u.set_ptr(8'h00);
        fork
            host_u.write_byte(1'b1, 1'b0, 8'h1B);
            pulse_deb();
        join
        `CHECK_EQ(fet_on_cmd, 1'b0);
        $display("test debounce done");
    endtask : t_debounce

    // alert pull, response, no re-pull while latched, address release
    task automatic t_alert();
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h02); // only undervoltage enabled
        pins.high_supply_comparator_pin = 1'b1;
        edges(3);
        `CHECK_EQ(alert_oe_n, 1'b1);
        pins.high_supply_comparator_pin = 1'b0;
        wr(8'h03, 8'h00);
        pins.low_supply_comparator_pin = 1'b0;
        edges(2);
        `CHECK_EQ(alert_oe_n, 1'b0);
        `CHECK_EQ(alert_o, 1'b0);
        rd(8'h03, v);
        `CHECK_EQ(v, 8'h02);
        host_u.ara_query(claim);
        `CHECK_EQ(claim, 1'b1);
        `CHECK_EQ(alert_oe_n, 1'b1);
        `CHECK_EQ(ara_data, {OWN_ADDR, 1'b0});
        pins.low_supply_comparator_pin = 1'b1;
        edges(2);
        pins.low_supply_comparator_pin = 1'b0;
        edges(2);
        `CHECK_EQ(alert_oe_n, 1'b1);
        wr(8'h03, 8'h00);
        pins.low_supply_comparator_pin = 1'b1;
        edges(2);
        pins.low_supply_comparator_pin = 1'b0;
        edges(2);
        `CHECK_EQ(alert_oe_n, 1'b0);
        host_u.addr_hit();
        `CHECK_EQ(alert_oe_n, 1'b1);
        $display("test alert done");
    endtask : t_alert

    // verdict; also reached by the watchdog
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_reset_ptr();
        t_ctrl_mass();
        t_status();
        t_gpio();
        t_debounce();
        t_alert();
        tally_and_finish();
    end

    // watchdog: tests need well under 1000 cycles
    initial begin
        #(40 * 5000);
        error_cnt++;
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
